// [hdl/ceb_pkg.sv]
// Package of constants for the completion entry builder
package ceb_pkg;
  // ---------------------------------------------------------------------
  // Entry geometry
  // ---------------------------------------------------------------------
  localparam int ENTRY_BYTES  = 16;
  localparam int ENTRY_WORDS  = 4;
  localparam int WORD_W       = 32;
  localparam int QIDX_W       = 16;
  localparam int QSIZE_W      = 17;
  // ---------------------------------------------------------------------
  // Word indices
  // ---------------------------------------------------------------------
  localparam logic [1:0] WORD_RESULT   = 2'h0;
  localparam logic [1:0] WORD_RESERVED = 2'h1;
  localparam logic [1:0] WORD_QUEUE    = 2'h2;
  localparam logic [1:0] WORD_STATUS   = 2'h3;
  // ---------------------------------------------------------------------
  // Field positions in the queue word and the status word
  // ---------------------------------------------------------------------
  localparam int QID_LSB      = 16;
  localparam int HEAD_LSB     = 0;
  localparam int NO_RETRY_BIT = 31;
  localparam int MORE_BIT     = 30;
  localparam int RSVD_LSB     = 28;
  localparam int CAT_LSB      = 25;
  localparam int CODE_LSB     = 17;
  localparam int PHASE_BIT    = 16;
  localparam int TAG_LSB      = 0;
  // ---------------------------------------------------------------------
  // Status categories, success code, reset values and buffer depth
  // ---------------------------------------------------------------------
  localparam logic [2:0] CAT_GENERIC  = 3'h0;
  localparam logic [2:0] CAT_CMD_SPEC = 3'h1;
  localparam logic [2:0] CAT_MEDIA    = 3'h2;
  localparam logic [2:0] CAT_IMPL     = 3'h7;
  localparam logic [7:0] CODE_SUCCESS = 8'h00;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
  localparam logic       PHASE_FIRST  = 1'b1;
  localparam int         BUF_DEPTH    = 2;
endpackage

// [hdl/ceb_skid_buffer.sv]
// Two-entry buffer carrying entry words to the memory writer
`timescale 1ns/1ps
module ceb_skid_buffer
  import ceb_pkg::*;
#(
  parameter int WIDTH = 50
) (
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  // -------------------------------------------------------------------
  // Storage
  // -------------------------------------------------------------------
  logic [WIDTH-1:0] mem_reg [BUF_DEPTH];
  logic             wr_ptr_reg;
  logic             rd_ptr_reg;
  logic [1:0]       count_reg;
  logic             push;
  logic             pop;

  // Handshakes on both faces
  assign push        = in_valid_i && (count_reg != 2'h2);
  assign pop         = out_valid_o && out_ready_i;
  assign in_ready_o  = (count_reg != 2'h2);
  assign out_valid_o = (count_reg != 2'h0);
  assign out_data_o  = mem_reg[rd_ptr_reg];

  // Write side
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers and occupancy; full stops the producer, not drops words
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  chk_full_refuse: assert property (@(posedge clock_i)
    disable iff (rst_i)
    (count_reg == 2'h2) |-> !in_ready_o)
    else $error("buffer accepts while full");
  chk_count_bound: assert property (@(posedge clock_i)
    disable iff (rst_i)
    count_reg <= 2'h2)
    else $error("buffer occupancy out of range");
endmodule

// [hdl/ceb_builder.sv]
// Completion entry builder: forms and streams 16-byte completion records
`timescale 1ns/1ps
// Summary of operation
// - Entry is four 32-bit words, 16 bytes
// - Word 0 carries result, else reserved zero
// - Word 1 reserved, written as zero
// - Word 2 upper half: source queue id
// - Word 2 lower half: head at creation
// - Word 3 bits 31:17 hold status field
// - Phase 1 first pass, inverts per wrap
// - Word 3 low half echoes command tag
// - Queue id with tag identifies command
// - All-zero status field means success
// - Multiple failures: controller picks one code
// - Bit 31 is the no-retry flag
// - Clear no-retry on success or recovery abort
// - Bit 30 flags more error log information
// - Bits 27:25 category, 29:28 zero
// - Bits 24:17 carry status detail code
// - Category encodings 0,1,2,7; 3-6 reserved
// - Lowest applicable status code is reported
module ceb_builder
  import ceb_pkg::*;
(
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  input  wire logic               controller_enable_bit_i,
  input  wire logic [QSIZE_W-1:0] queue_size_i,
  input  wire logic               req_valid_i,
  output logic                    req_ready_o,
  input  wire logic               result_used_i,
  input  wire logic [WORD_W-1:0]  result_word_i,
  input  wire logic [QIDX_W-1:0]  source_queue_id_i,
  input  wire logic [QIDX_W-1:0]  source_queue_head_i,
  input  wire logic [QIDX_W-1:0]  command_tag_i,
  input  wire logic [2:0]         status_category_i,
  input  wire logic [7:0]         code_mask_i,
  input  wire logic               more_info_i,
  input  wire logic               retry_hopeless_i,
  input  wire logic               recovery_abort_i,
  output logic                    wr_valid_o,
  input  wire logic               wr_ready_i,
  output logic [QIDX_W-1:0]       wr_slot_o,
  output logic [1:0]              wr_word_o,
  output logic [WORD_W-1:0]       wr_data_o,
  output logic                    wr_last_o,
  output logic                    phase_o,
  output logic [QIDX_W-1:0]       tail_o,
  output logic                    bad_category_o
);
  // -------------------------------------------------------------------
  // Types and state
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_EMIT} ceb_state_type;
  localparam int PKT_W = QIDX_W + 2 + WORD_W;

  ceb_state_type         state_reg;
  logic [WORD_W-1:0]     words_reg [ENTRY_WORDS];
  logic [1:0]            word_idx_reg;
  logic [QIDX_W-1:0]     slot_reg;
  logic [QIDX_W-1:0]     tail_reg;
  logic [QIDX_W-1:0]     tail_next;
  logic                  phase_reg;
  logic                  bad_cat_reg;
  logic                  wr_last_reg;
  logic                  accept;
  logic                  buf_ready;
  logic [PKT_W-1:0]      buf_out;
  logic                  buf_valid;
  logic [7:0]            code_pick;
  logic [WORD_W-1:0]     status_word;
  logic                  no_retry;
  logic                  wr_valid_reg;
  logic [PKT_W-1:0]      wr_pkt_reg;

  // -------------------------------------------------------------------
  // Status word composition
  // -------------------------------------------------------------------
  // Lowest set bit of the mask is the reported code; with several
  // failure causes this is how the single code is chosen.
  always_comb begin
    code_pick = CODE_SUCCESS;
    for (int i = 7; i >= 0; i--) begin
      if (code_mask_i[i]) begin
        code_pick = 8'(i);
      end
    end
  end

  // No-retry is dropped for success and time-limited recovery aborts
  assign no_retry = retry_hopeless_i && !recovery_abort_i
                    && !((status_category_i == CAT_GENERIC)
                         && (code_pick == CODE_SUCCESS));

  // Field packing; reserved bits 29:28 held at zero
  always_comb begin
    status_word                          = WORD_ZERO;
    status_word[NO_RETRY_BIT]            = no_retry;
    status_word[MORE_BIT]                = more_info_i;
    status_word[CAT_LSB+2:CAT_LSB]       = status_category_i;
    status_word[CODE_LSB+7:CODE_LSB]     = code_pick;
    status_word[PHASE_BIT]               = phase_reg;
    status_word[TAG_LSB+15:TAG_LSB]      = command_tag_i;
  end

  // -------------------------------------------------------------------
  // Request acceptance and entry capture
  // -------------------------------------------------------------------
  assign accept      = req_valid_i && (state_reg == ST_IDLE)
                       && controller_enable_bit_i;
  assign req_ready_o = (state_reg == ST_IDLE) && controller_enable_bit_i;

  // Snapshot every field at acceptance so a moving head is not seen
  always_ff @(posedge clock_i) begin
    if (accept) begin
      words_reg[WORD_RESULT]   <= result_used_i ? result_word_i
                                                : WORD_ZERO;
      words_reg[WORD_RESERVED] <= WORD_ZERO;
      words_reg[WORD_QUEUE]    <= {source_queue_id_i,
                                   source_queue_head_i};
      words_reg[WORD_STATUS]   <= status_word;
      slot_reg                 <= tail_reg;
    end
  end

  // Flag categories that fall in the reserved range
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bad_cat_reg <= 1'b0;
    end else if (accept) begin
      bad_cat_reg <= (status_category_i > CAT_MEDIA)
                     && (status_category_i != CAT_IMPL);
    end
  end

  // -------------------------------------------------------------------
  // Word sequencer: four words, ascending, then release
  // -------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg    <= ST_IDLE;
      word_idx_reg <= WORD_RESULT;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            state_reg    <= ST_EMIT;
            word_idx_reg <= WORD_RESULT;
          end
        end
        ST_EMIT: begin
          if (buf_ready) begin
            word_idx_reg <= word_idx_reg + 2'h1;
            if (word_idx_reg == WORD_STATUS) begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Tail index and phase tag
  // -------------------------------------------------------------------
  assign tail_next = (QSIZE_W'(tail_reg) + 17'h0_0001 >= queue_size_i)
                     ? '0 : tail_reg + 16'h0001;

  // Disable resets the pass; each wrap inverts the phase
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tail_reg  <= '0;
      phase_reg <= PHASE_FIRST;
    end else begin
      if (!controller_enable_bit_i) begin
        tail_reg  <= '0;
        phase_reg <= PHASE_FIRST;
      end else if (accept) begin
        tail_reg <= tail_next;
        if (tail_next == '0) begin
          phase_reg <= ~phase_reg;
        end
      end
    end
  end

  // -------------------------------------------------------------------
  // Buffer toward memory and registered output stage
  // -------------------------------------------------------------------
  ceb_skid_buffer #(
    .WIDTH (PKT_W)
  ) u_buf (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .in_data_i   ({slot_reg, word_idx_reg, words_reg[word_idx_reg]}),
    .in_valid_i  (state_reg == ST_EMIT),
    .in_ready_o  (buf_ready),
    .out_data_o  (buf_out),
    .out_valid_o (buf_valid),
    .out_ready_i (!wr_valid_reg || wr_ready_i)
  );

  // Output register keeps every memory write output on a flip-flop; req_ready_o stays combinational
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_valid_reg <= 1'b0;
      wr_pkt_reg   <= '0;
      wr_last_reg  <= 1'b0;
    end else if (!wr_valid_reg || wr_ready_i) begin
      wr_valid_reg <= buf_valid;
      wr_pkt_reg   <= buf_out;
      wr_last_reg  <= (buf_out[WORD_W+1:WORD_W] == WORD_STATUS);
    end
  end

  assign wr_valid_o     = wr_valid_reg;
  assign wr_slot_o      = wr_pkt_reg[PKT_W-1 -: QIDX_W];
  assign wr_word_o      = wr_pkt_reg[WORD_W+1:WORD_W];
  assign wr_data_o      = wr_pkt_reg[WORD_W-1:0];
  assign wr_last_o      = wr_last_reg;
  assign phase_o        = phase_reg;
  assign tail_o         = tail_reg;
  assign bad_category_o = bad_cat_reg;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  sequence emit_start;
    (state_reg == ST_EMIT) && (word_idx_reg == WORD_RESULT);
  endsequence
  // One buffer handshake moves the word index by exactly one
  sequence word_step;
    (state_reg == ST_EMIT) && buf_ready;
  endsequence

  chk_reserved_zero: assert property (@(posedge clock_i)
    disable iff (rst_i)
    wr_valid_o && wr_word_o == WORD_RESERVED |-> wr_data_o == WORD_ZERO)
    else $error("reserved word not zero");
  chk_status_rsvd: assert property (@(posedge clock_i)
    disable iff (rst_i)
    wr_valid_o && wr_last_o |-> wr_data_o[RSVD_LSB+1:RSVD_LSB] == 2'h0)
    else $error("status reserved bits set");
  chk_success_retry: assert property (@(posedge clock_i)
    disable iff (rst_i)
    wr_valid_o && wr_last_o && wr_data_o[27:17] == 11'h000
    |-> !wr_data_o[NO_RETRY_BIT])
    else $error("no-retry set on success");
  chk_phase_first: assert property (@(posedge clock_i)
    disable iff (rst_i)
    !controller_enable_bit_i |=> phase_reg && tail_reg == '0)
    else $error("phase not reset on disable");
  chk_phase_wrap: assert property (@(posedge clock_i)
    disable iff (rst_i)
    accept && controller_enable_bit_i && tail_next == '0
    |=> phase_reg != $past(phase_reg))
    else $error("phase not inverted on wrap");
  chk_tail_step: assert property (@(posedge clock_i)
    disable iff (rst_i)
    accept && tail_next != '0 |=> tail_reg == $past(tail_reg) + 16'h0001)
    else $error("tail step wrong");
  chk_word_order: assert property (@(posedge clock_i)
    disable iff (rst_i)
    emit_start ##0 buf_ready |=> word_idx_reg == 2'h1)
    else $error("words out of order");
  chk_code_lowest: assert property (@(posedge clock_i)
    disable iff (rst_i)
    code_mask_i[0] |-> code_pick == 8'h00)
    else $error("lowest code not picked");
  chk_head_snap: assert property (@(posedge clock_i)
    disable iff (rst_i)
    accept |=> words_reg[WORD_QUEUE] ==
      {$past(source_queue_id_i), $past(source_queue_head_i)})
    else $error("queue word not captured");
  chk_tag_echo: assert property (@(posedge clock_i)
    disable iff (rst_i)
    accept |=> words_reg[WORD_STATUS][15:0] == $past(command_tag_i))
    else $error("command tag not echoed");
  chk_word_advance: assert property (@(posedge clock_i)
    disable iff (rst_i)
    word_step |=> word_idx_reg == $past(word_idx_reg) + 2'h1)
    else $error("word index skipped a step");
  chk_entry_end: assert property (@(posedge clock_i)
    disable iff (rst_i)
    word_step ##0 (word_idx_reg == WORD_STATUS) |=> state_reg == ST_IDLE)
    else $error("entry did not end after word 3");
  chk_busy_refuse: assert property (@(posedge clock_i)
    disable iff (rst_i)
    state_reg == ST_EMIT |-> !req_ready_o)
    else $error("request taken while emitting");
  chk_result_zero: assert property (@(posedge clock_i)
    disable iff (rst_i)
    accept && !result_used_i |=> words_reg[WORD_RESULT] == WORD_ZERO)
    else $error("unused result word not zero");
  chk_more_flag: assert property (@(posedge clock_i)
    disable iff (rst_i)
    accept |=> words_reg[WORD_STATUS][MORE_BIT] == $past(more_info_i))
    else $error("more flag not captured");
  chk_abort_retry: assert property (@(posedge clock_i)
    disable iff (rst_i)
    accept && recovery_abort_i |=> !words_reg[WORD_STATUS][NO_RETRY_BIT])
    else $error("no-retry set on recovery abort");
  chk_phase_field: assert property (@(posedge clock_i)
    disable iff (rst_i)
    accept |=> words_reg[WORD_STATUS][PHASE_BIT] == $past(phase_reg))
    else $error("entry phase is not the pass phase");
  chk_category_flag: assert property (@(posedge clock_i)
    disable iff (rst_i)
    accept && status_category_i inside {[3'h3:3'h6]} |=> bad_category_o)
    else $error("reserved category not flagged");
  chk_last_flag: assert property (@(posedge clock_i)
    disable iff (rst_i)
    wr_valid_o |-> wr_last_o == (wr_word_o == WORD_STATUS))
    else $error("last flag not on word 3");
  chk_output_hold: assert property (@(posedge clock_i)
    disable iff (rst_i)
    wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_data_o))
    else $error("word dropped before memory took it");
endmodule

// [sim/ceb_host_mem.sv]
// Memory-side model that takes entry words, with an optional stall
`timescale 1ns/1ps
module ceb_host_mem
  import ceb_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              stall_i,
  input  wire logic              wr_valid_i,
  output logic                   wr_ready_o,
  input  wire logic [QIDX_W-1:0] wr_slot_i,
  input  wire logic [1:0]        wr_word_i,
  input  wire logic [WORD_W-1:0] wr_data_i,
  input  wire logic              wr_last_i,
  output int                     words_o,
  output logic                   order_err_o
);
  logic [31:0] mem_q [0:7][0:3];
  logic [1:0]  exp_word_q;
  logic [1:0]  pace_q;
  // ---------------------------------------------------------------
  // Ready pacing
  // ---------------------------------------------------------------
  // Stalling drops ready three cycles in four, so the buffer must hold
  always_ff @(posedge clock_i) begin
    pace_q     <= rst_i ? 2'h0 : pace_q + 2'h1;
    wr_ready_o <= !rst_i && (!stall_i || pace_q == 2'h3);
  end
  // ---------------------------------------------------------------
  // Queue memory
  // ---------------------------------------------------------------
  // Tags start cleared so a stale entry never looks new
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int s = 0; s < 8; s++) begin
        for (int w = 0; w < 4; w++) begin
          mem_q[s][w] <= 32'h0000_0000;
        end
      end
      words_o     <= 0;
      exp_word_q  <= 2'h0;
      order_err_o <= 1'b0;
    end else if (wr_valid_i && wr_ready_o) begin
      mem_q[wr_slot_i[2:0]][wr_word_i] <= wr_data_i;
      words_o    <= words_o + 1;
      exp_word_q <= exp_word_q + 2'h1;
      if (wr_word_i !== exp_word_q || wr_last_i !== (wr_word_i == 2'h3)) begin
        order_err_o <= 1'b1;
      end
    end
  end
endmodule

// [sim/completion_entry_builder_tb.sv]
// Self-checking bench for the completion entry builder
`timescale 1ns/1ps
module completion_entry_builder_tb
  import ceb_pkg::*;
;
  logic clock_i = 1'b0, rst_i = 1'b1, enable = 1'b1, req_valid_i = 1'b0;
  logic [16:0] qsize = 17'h0_0003;
  logic used = 1'b0, more = 1'b0, hopeless = 1'b0, abort = 1'b0;
  logic [31:0] res = 32'h0000_0000;
  logic [15:0] qid = 16'h0000, head = 16'h0000, tag = 16'h0000;
  logic [2:0] cat = 3'h0;
  logic [7:0] mask = 8'h00;
  logic stall = 1'b0, req_ready, wr_valid, wr_ready, wr_last, phase, badc;
  logic [15:0] wr_slot, tail;
  logic [1:0]  wr_word;
  logic [31:0] wr_data;
  logic        order_err;
  int          words, bad_count = 0, n_tests = 0, exp_tail = 0;
  logic        exp_phase = 1'b1;
  logic [2:0]  cats  [7] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h3, 3'h6, 3'h4};
  logic [7:0]  masks [7] = '{8'h00, 8'h06, 8'h80, 8'h0C, 8'h00, 8'h01, 8'h00};
  logic [2:0]  flags [7] = '{3'h2, 3'h6, 3'h3, 3'h0, 3'h2, 3'h4, 3'h3};

  ceb_builder i_dut (.clock_i(clock_i), .rst_i(rst_i),
    .controller_enable_bit_i(enable), .queue_size_i(qsize),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready),
    .result_used_i(used), .result_word_i(res), .source_queue_id_i(qid),
    .source_queue_head_i(head), .command_tag_i(tag),
    .status_category_i(cat), .code_mask_i(mask), .more_info_i(more),
    .retry_hopeless_i(hopeless), .recovery_abort_i(abort),
    .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_slot_o(wr_slot),
    .wr_word_o(wr_word), .wr_data_o(wr_data), .wr_last_o(wr_last),
    .phase_o(phase), .tail_o(tail), .bad_category_o(badc));

  ceb_host_mem i_host (.clock_i(clock_i), .rst_i(rst_i), .stall_i(stall),
    .wr_valid_i(wr_valid), .wr_ready_o(wr_ready), .wr_slot_i(wr_slot),
    .wr_word_i(wr_word), .wr_data_i(wr_data), .wr_last_i(wr_last),
    .words_o(words), .order_err_o(order_err));

  // Free-running 100 MHz clock
  always #5 clock_i = ~clock_i;

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Posts one completion and checks the four words landed in memory
  task automatic post(input int i);
    logic [7:0]  code;
    logic        no_retry_flag;
    logic [31:0] w3;
    int          start, slot, n;
    code = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      if (masks[i][b]) code = 8'(b);
    end
    no_retry_flag = flags[i][1] && !flags[i][0] && !(cats[i] == 3'h0 && code == 8'h00);
    start = words;
    slot = exp_tail;
    @(posedge clock_i);
    used <= i[0];
    res <= 32'hC0DE_0000 + 32'(i);
    qid <= 16'(i + 1);
    head <= 16'(40 - i);
    tag <= 16'(16'hFF00 + i);
    cat <= cats[i];
    mask <= masks[i];
    {more, hopeless, abort} <= flags[i];
    req_valid_i <= 1'b1;
    do @(posedge clock_i); while (req_ready !== 1'b1);
    req_valid_i <= 1'b0;
    w3 = {no_retry_flag, flags[i][2], 2'b00, cats[i], code, exp_phase, 16'(16'hFF00 + i)};
    n = 0;
    while (words != start + 4 && n < 60) begin
      @(posedge clock_i);
      n++;
    end
    #1;
    check("word count", 32'(start + 4), 32'(words));
    check("word0", i[0] ? 32'hC0DE_0000 + 32'(i) : 32'h0, i_host.mem_q[slot][0]);
    check("word1", 32'h0000_0000, i_host.mem_q[slot][1]);
    check("word2", {16'(i + 1), 16'(40 - i)}, i_host.mem_q[slot][2]);
    check("word3", w3, i_host.mem_q[slot][3]);
    check("bad_cat", 32'(cats[i] inside {[3'h3:3'h6]}), 32'(badc));
    if (exp_tail == int'(qsize) - 1) begin
      exp_tail = 0;
      exp_phase = !exp_phase;
    end else begin
      exp_tail++;
    end
    check("tail", 32'(exp_tail), 32'(tail));
    check("phase", 32'(exp_phase), 32'(phase));
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    #1;
    check("reset tail", 32'h0, 32'(tail));
    check("reset phase", 32'h1, 32'(phase));
    check("reset valid", 32'h0, 32'(wr_valid));
    check("reset flag", 32'h0, 32'(badc));
    $display("test reset done");
    // Ten entries through a three-slot queue cross three wraps, so the
    // restart below begins from a nonzero tail and a cleared phase
    for (int i = 0; i < 10; i++) begin
      stall <= i[0];
      post(i % 7);
    end
    $display("test entries done");
    // Dropping enable restarts at slot 0 with phase 1
    @(posedge clock_i);
    enable <= 1'b0;
    @(posedge clock_i);
    enable <= 1'b1;
    #1;
    check("restart tail", 32'h0, 32'(tail));
    check("restart phase", 32'h1, 32'(phase));
    exp_tail = 0;
    exp_phase = 1'b1;
    stall <= 1'b1;
    post(1);
    check("order", 32'h0, 32'(order_err));
    $display("test restart done");
    results();
  end

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #100000;
    bad_count++;
    results();
  end
endmodule
